// ### core/bads_defines.svh
/*
  Constants for the byte-addressed data space: address map edges, widths
  and program window address layout.
  Assumes inclusion by bare name from files under core/.
*/
`ifndef BADS_DEFINES_SVH
`define BADS_DEFINES_SVH

`define BADS_ADDR_W      16
`define BADS_DATA_W      16
`define BADS_NEAR_W      13
`define BADS_SFR_END     16'h07FF
`define BADS_RAM_END     16'h0FFF
`define BADS_RAM_WORDS   1024
`define BADS_RAM_AW      10
`define BADS_SFR_AW      10
`define BADS_PAGE_W      8
`define BADS_PW_LOW_W    15
`define BADS_PW_ADDR_W   23
`define BADS_BYTE_STEP   16'h0001
`define BADS_WORD_STEP   16'h0002

`endif

// ### core/bads_pkg.sv
/*
  Types shared by the data space modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bads_pkg;

  // how the address generator forms the effective address
  typedef enum logic [1:0] {
    BADS_AM_NEAR     = 2'h0,
    BADS_AM_DIRECT   = 2'h1,
    BADS_AM_INDIRECT = 2'h2
  } bads_amode_e;

  // operation on a loaded value before it reaches the working register
  typedef enum logic [1:0] {
    BADS_XOP_LOAD        = 2'h0,
    BADS_XOP_SIGN_EXTEND = 2'h1,
    BADS_XOP_CLEAR_UPPER = 2'h2
  } bads_xop_e;

  typedef enum logic [1:0] {
    BADS_RG_SFR  = 2'h0,
    BADS_RG_RAM  = 2'h1,
    BADS_RG_NONE = 2'h2,
    BADS_RG_PW   = 2'h3
  } bads_region_e;

endpackage : bads_pkg

// ### core/bads_mem_if.sv
/*
  Link between the data space decoder and its word-organised array.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`include "bads_defines.svh"

interface bads_mem_if;
  logic                      rd_en;
  logic [`BADS_RAM_AW-1:0]   rd_addr;
  logic [`BADS_DATA_W-1:0]   rd_data;
  logic [`BADS_RAM_AW-1:0]   wr_addr;
  logic [1:0]                wr_lane;
  logic [`BADS_DATA_W-1:0]   wr_data;

  modport ctrl (output rd_en, output rd_addr, input rd_data,
                output wr_addr, output wr_lane, output wr_data);
  modport mem  (input rd_en, input rd_addr, output rd_data,
                input wr_addr, input wr_lane, input wr_data);
endinterface : bads_mem_if

// ### core/bads_mem.sv
/*
  2 Kbyte data array as two byte-wide halves with a shared word decode.
  Assumes the decoder never reads and writes through the same port; read
  of a word written in the same cycle returns the old contents.
*/
`timescale 1ns/1ps
`include "bads_defines.svh"

module bads_mem (
  // clock
  input wire logic core_clk,
  // array port
  bads_mem_if.mem  port
);

  genvar lane;
  generate
    for (lane = 0; lane < 2; lane = lane + 1) begin : g_lane
      logic [7:0] bytes [`BADS_RAM_WORDS];
      logic [7:0] rd_reg;
      always_ff @(posedge core_clk) begin
        if (port.wr_lane[lane]) begin
          bytes[port.wr_addr] <= port.wr_data[lane*8 +: 8];
        end
        if (port.rd_en) begin
          rd_reg <= bytes[port.rd_addr];
        end
      end
      // lane 0 is the even byte, lane 1 the odd byte
      assign port.rd_data[lane*8 +: 8] = rd_reg;
    end
  endgenerate

endmodule : bads_mem

// ### core/bads_data_space.sv
/*
  Data space decoder: forms read and write effective addresses, routes them
  to special registers or the data array, reads also to the program window,
  handles byte lanes and raises the address error trap.
  Assumes the special register block answers sfr_rd_data/sfr_rd_hit and the
  program window answers pw_rd_data in the cycle its enable is high.
*/
`timescale 1ns/1ps
`include "bads_defines.svh"

module bads_data_space (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  // read address generator
  input  wire logic                        rd_req,
  input  wire bads_pkg::bads_amode_e       rd_mode,
  input  wire logic [`BADS_ADDR_W-1:0]     rd_field,
  input  wire logic [`BADS_ADDR_W-1:0]     rd_ptr,
  input  wire logic                        rd_is_byte,
  input  wire bads_pkg::bads_xop_e         rd_op,
  input  wire logic [`BADS_DATA_W-1:0]     rd_wreg_old,
  // read answer
  output logic                             rd_valid,
  output logic [`BADS_DATA_W-1:0]          rd_data,
  output logic [`BADS_DATA_W-1:0]          rd_wreg_result,
  output logic [`BADS_ADDR_W-1:0]          rd_ptr_next,
  // write address generator
  input  wire logic                        wr_req,
  input  wire bads_pkg::bads_amode_e       wr_mode,
  input  wire logic [`BADS_ADDR_W-1:0]     wr_field,
  input  wire logic [`BADS_ADDR_W-1:0]     wr_ptr,
  input  wire logic                        wr_is_byte,
  input  wire logic [`BADS_DATA_W-1:0]     wr_data,
  // write answer
  output logic                             wr_done,
  output logic [`BADS_ADDR_W-1:0]          wr_ptr_next,
  // special registers
  output logic                             sfr_rd_en,
  output logic [`BADS_SFR_AW-1:0]          sfr_rd_addr,
  input  wire logic [`BADS_DATA_W-1:0]     sfr_rd_data,
  input  wire logic                        sfr_rd_hit,
  output logic                             sfr_wr_en,
  output logic [`BADS_SFR_AW-1:0]          sfr_wr_addr,
  output logic [1:0]                       sfr_wr_lane,
  output logic [`BADS_DATA_W-1:0]          sfr_wr_data,
  // program window
  input  wire logic [`BADS_PAGE_W-1:0]     program_window_page,
  output logic                             pw_rd_en,
  output logic [`BADS_PW_ADDR_W-1:0]       pw_rd_addr,
  input  wire logic [`BADS_DATA_W-1:0]     pw_rd_data,
  // address error trap
  output logic                             addr_err_trap,
  output logic                             addr_err_on_read,
  output logic                             addr_err_on_write
);

  // effective address from the generator's mode
  function automatic logic [`BADS_ADDR_W-1:0] ea_f(
    input bads_pkg::bads_amode_e     mode,
    input logic [`BADS_ADDR_W-1:0]   field,
    input logic [`BADS_ADDR_W-1:0]   ptr
  );
    logic [`BADS_ADDR_W-1:0] ea;
    ea = field;
    case (mode)
      bads_pkg::BADS_AM_NEAR:     ea = {3'h0, field[`BADS_NEAR_W-1:0]};
      bads_pkg::BADS_AM_DIRECT:   ea = field;
      bads_pkg::BADS_AM_INDIRECT: ea = ptr;
      default:                    ea = field;
    endcase
    return ea;
  endfunction : ea_f

  // region that a byte address falls in
  function automatic bads_pkg::bads_region_e region_f(input logic [`BADS_ADDR_W-1:0] ea);
    bads_pkg::bads_region_e rg;
    rg = bads_pkg::BADS_RG_NONE;
    if (ea[`BADS_ADDR_W-1]) begin
      rg = bads_pkg::BADS_RG_PW;
    end else if (ea <= `BADS_SFR_END) begin
      rg = bads_pkg::BADS_RG_SFR;
    end else if (ea <= `BADS_RAM_END) begin
      rg = bads_pkg::BADS_RG_RAM;
    end
    return rg;
  endfunction : region_f

  bads_mem_if mem_port ();

  // read side decode, cycle 0
  logic [`BADS_ADDR_W-1:0]   rd_ea;
  bads_pkg::bads_region_e    rd_region;
  logic                      rd_misalign;
  logic [`BADS_ADDR_W-1:0]   rd_ptr_step;

  assign rd_ea       = ea_f(rd_mode, rd_field, rd_ptr);
  assign rd_region   = region_f(rd_ea);
  assign rd_misalign = !rd_is_byte && rd_ea[0];
  assign rd_ptr_step = rd_is_byte ? `BADS_BYTE_STEP : `BADS_WORD_STEP;

  // write side decode, cycle 0, separate generator
  logic [`BADS_ADDR_W-1:0]   wr_ea;
  bads_pkg::bads_region_e    wr_region;
  logic                      wr_misalign;
  logic                      wr_allowed;
  logic [1:0]                wr_lane_sel;
  logic [`BADS_DATA_W-1:0]   wr_lane_data;
  logic [`BADS_ADDR_W-1:0]   wr_ptr_step;

  assign wr_ea        = ea_f(wr_mode, wr_field, wr_ptr);
  assign wr_region    = region_f(wr_ea);
  assign wr_misalign  = !wr_is_byte && wr_ea[0];
  // a misaligned word write never reaches any target
  assign wr_allowed   = wr_req && !wr_misalign;
  assign wr_lane_sel  = wr_is_byte ? {wr_ea[0], !wr_ea[0]} : 2'h3;
  assign wr_lane_data = wr_is_byte ? {wr_data[7:0], wr_data[7:0]} : wr_data;
  assign wr_ptr_step  = wr_is_byte ? `BADS_BYTE_STEP : `BADS_WORD_STEP;

  // array connection; word index is half the byte offset inside the array window
  assign mem_port.rd_en   = rd_req && (rd_region == bads_pkg::BADS_RG_RAM);
  assign mem_port.rd_addr = rd_ea[`BADS_RAM_AW:1];
  assign mem_port.wr_addr = wr_ea[`BADS_RAM_AW:1];
  assign mem_port.wr_lane = (wr_allowed && wr_region == bads_pkg::BADS_RG_RAM) ? wr_lane_sel : 2'h0;
  assign mem_port.wr_data = wr_lane_data;

  bads_mem u_mem (
    .core_clk (core_clk),
    .port     (mem_port.mem)
  );

  // read stage 1: targets answer during this cycle
  logic                      s1_valid_reg;
  bads_pkg::bads_region_e    s1_region_reg;
  logic                      s1_byte_reg;
  logic                      s1_lane_reg;
  logic                      s1_misalign_reg;
  bads_pkg::bads_xop_e       s1_op_reg;
  logic [`BADS_DATA_W-1:0]   s1_wreg_reg;
  logic [`BADS_ADDR_W-1:0]   s1_ptr_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_valid_reg    <= 1'b0;
      s1_region_reg   <= bads_pkg::BADS_RG_NONE;
      s1_byte_reg     <= 1'b0;
      s1_lane_reg     <= 1'b0;
      s1_misalign_reg <= 1'b0;
      s1_op_reg       <= bads_pkg::BADS_XOP_LOAD;
      s1_wreg_reg     <= 16'h0000;
      s1_ptr_reg      <= 16'h0000;
    end else begin
      s1_valid_reg    <= rd_req;
      s1_region_reg   <= rd_region;
      s1_byte_reg     <= rd_is_byte;
      s1_lane_reg     <= rd_ea[0];
      s1_misalign_reg <= rd_req && rd_misalign;
      s1_op_reg       <= rd_op;
      s1_wreg_reg     <= rd_wreg_old;
      s1_ptr_reg      <= rd_ptr + rd_ptr_step;
    end
  end

  // requests toward special registers and program window, cycle 1
  logic                      sfr_rd_en_reg;
  logic [`BADS_SFR_AW-1:0]   sfr_rd_addr_reg;
  logic                      pw_rd_en_reg;
  logic [`BADS_PW_ADDR_W-1:0] pw_rd_addr_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rd_en_reg   <= 1'b0;
      sfr_rd_addr_reg <= 10'h000;
      pw_rd_en_reg    <= 1'b0;
      pw_rd_addr_reg  <= 23'h000000;
    end else begin
      sfr_rd_en_reg   <= rd_req && (rd_region == bads_pkg::BADS_RG_SFR);
      sfr_rd_addr_reg <= rd_ea[`BADS_SFR_AW:1];
      pw_rd_en_reg    <= rd_req && (rd_region == bads_pkg::BADS_RG_PW);
      pw_rd_addr_reg  <= {program_window_page, rd_ea[`BADS_PW_LOW_W-1:0]};
    end
  end

  // word returned by the addressed target; anything unimplemented gives zero
  logic [`BADS_DATA_W-1:0]   s1_word;
  logic [7:0]                s1_byte_sel;
  logic [`BADS_DATA_W-1:0]   s1_bus;
  logic [`BADS_DATA_W-1:0]   s1_wreg_next;

  assign s1_word = (s1_region_reg == bads_pkg::BADS_RG_RAM) ? mem_port.rd_data :
                   (s1_region_reg == bads_pkg::BADS_RG_SFR && sfr_rd_hit) ? sfr_rd_data :
                   (s1_region_reg == bads_pkg::BADS_RG_PW) ? pw_rd_data :
                   16'h0000;
  assign s1_byte_sel = s1_lane_reg ? s1_word[15:8] : s1_word[7:0];
  assign s1_bus      = s1_byte_reg ? {8'h00, s1_byte_sel} : s1_word;

  // working register result: byte load keeps the upper byte
  assign s1_wreg_next =
    (s1_op_reg == bads_pkg::BADS_XOP_SIGN_EXTEND) ? {{8{s1_bus[7]}}, s1_bus[7:0]} :
    (s1_op_reg == bads_pkg::BADS_XOP_CLEAR_UPPER) ? {8'h00, s1_bus[7:0]} :
    s1_byte_reg ? {s1_wreg_reg[15:8], s1_bus[7:0]} :
    s1_bus;

  // read stage 2: answer registers
  logic                      rd_valid_reg;
  logic [`BADS_DATA_W-1:0]   rd_data_reg;
  logic [`BADS_DATA_W-1:0]   rd_wreg_result_reg;
  logic [`BADS_ADDR_W-1:0]   rd_ptr_next_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_valid_reg       <= 1'b0;
      rd_data_reg        <= 16'h0000;
      rd_wreg_result_reg <= 16'h0000;
      rd_ptr_next_reg    <= 16'h0000;
    end else begin
      // misaligned reads still complete so the instruction finishes
      rd_valid_reg       <= s1_valid_reg;
      rd_data_reg        <= s1_bus;
      rd_wreg_result_reg <= s1_wreg_next;
      rd_ptr_next_reg    <= s1_ptr_reg;
    end
  end

  // write answer and special register write, cycle 1
  logic                      wr_done_reg;
  logic [`BADS_ADDR_W-1:0]   wr_ptr_next_reg;
  logic                      sfr_wr_en_reg;
  logic [`BADS_SFR_AW-1:0]   sfr_wr_addr_reg;
  logic [1:0]                sfr_wr_lane_reg;
  logic [`BADS_DATA_W-1:0]   sfr_wr_data_reg;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_done_reg     <= 1'b0;
      wr_ptr_next_reg <= 16'h0000;
      sfr_wr_en_reg   <= 1'b0;
      sfr_wr_addr_reg <= 10'h000;
      sfr_wr_lane_reg <= 2'h0;
      sfr_wr_data_reg <= 16'h0000;
    end else begin
      // instruction still executes: done and pointer update stand
      wr_done_reg     <= wr_req;
      wr_ptr_next_reg <= wr_ptr + wr_ptr_step;
      // program window is read only, so writes there are dropped
      sfr_wr_en_reg   <= wr_allowed && (wr_region == bads_pkg::BADS_RG_SFR);
      sfr_wr_addr_reg <= wr_ea[`BADS_SFR_AW:1];
      sfr_wr_lane_reg <= wr_lane_sel;
      sfr_wr_data_reg <= wr_lane_data;
    end
  end

  // address error trap; write errors show one cycle before read errors
  logic                      trap_rd_next;
  logic                      trap_wr_next;
  logic                      addr_err_trap_reg;
  logic                      addr_err_on_read_reg;
  logic                      addr_err_on_write_reg;

  assign trap_rd_next = s1_misalign_reg;
  assign trap_wr_next = wr_req && wr_misalign;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_err_trap_reg     <= 1'b0;
      addr_err_on_read_reg  <= 1'b0;
      addr_err_on_write_reg <= 1'b0;
    end else begin
      addr_err_trap_reg     <= trap_rd_next || trap_wr_next;
      addr_err_on_read_reg  <= trap_rd_next;
      addr_err_on_write_reg <= trap_wr_next;
    end
  end

  assign rd_valid          = rd_valid_reg;
  assign rd_data           = rd_data_reg;
  assign rd_wreg_result    = rd_wreg_result_reg;
  assign rd_ptr_next       = rd_ptr_next_reg;
  assign wr_done           = wr_done_reg;
  assign wr_ptr_next       = wr_ptr_next_reg;
  assign sfr_rd_en         = sfr_rd_en_reg;
  assign sfr_rd_addr       = sfr_rd_addr_reg;
  assign sfr_wr_en         = sfr_wr_en_reg;
  assign sfr_wr_addr       = sfr_wr_addr_reg;
  assign sfr_wr_lane       = sfr_wr_lane_reg;
  assign sfr_wr_data       = sfr_wr_data_reg;
  assign pw_rd_en          = pw_rd_en_reg;
  assign pw_rd_addr        = pw_rd_addr_reg;
  assign addr_err_trap     = addr_err_trap_reg;
  assign addr_err_on_read  = addr_err_on_read_reg;
  assign addr_err_on_write = addr_err_on_write_reg;

endmodule : bads_data_space

// ### dv/bads_far_model.sv
/*
  Far side model: special register block and program window responder.
  Assumes the decoder samples both read answers in the cycle the enable is high.
*/
`timescale 1ns/1ps

module bads_far_model (
  // clock
  input  wire logic        core_clk,
  // special register block
  input  wire logic        sfr_rd_en,
  input  wire logic [9:0]  sfr_rd_addr,
  output logic      [15:0] sfr_rd_data,
  output logic             sfr_rd_hit,
  input  wire logic        sfr_wr_en,
  input  wire logic [9:0]  sfr_wr_addr,
  input  wire logic [1:0]  sfr_wr_lane,
  input  wire logic [15:0] sfr_wr_data,
  // program window
  input  wire logic        pw_rd_en,
  input  wire logic [22:0] pw_rd_addr,
  output logic      [15:0] pw_rd_data
);
  logic [15:0] regs [0:7];
  logic [15:0] idle_pat = 16'h5A5A;
  wire         rd_hit = sfr_rd_en && (sfr_rd_addr < 10'h008);
  wire         wr_hit = sfr_wr_en && (sfr_wr_addr < 10'h008);

  // idle answer changes every cycle so a stale sample shows
  always @(posedge core_clk) begin
    idle_pat <= ~idle_pat;
    if (wr_hit && sfr_wr_lane[0]) regs[sfr_wr_addr[2:0]][7:0] <= sfr_wr_data[7:0];
    if (wr_hit && sfr_wr_lane[1]) regs[sfr_wr_addr[2:0]][15:8] <= sfr_wr_data[15:8];
  end
  assign sfr_rd_hit  = rd_hit;
  assign sfr_rd_data = rd_hit ? regs[sfr_rd_addr[2:0]] : idle_pat;
  assign pw_rd_data  = pw_rd_en ? (pw_rd_addr[15:0] ^ {pw_rd_addr[22:15], 8'hC3}) : ~idle_pat;
endmodule : bads_far_model

// ### dv/bads_data_space_chk.sv
/*
  Concurrent checks on the data space decoder ports.
  Assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/1ps

module bads_data_space_chk (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  reset,
  // read generator and answer
  input wire logic                  rd_req,
  input wire bads_pkg::bads_amode_e rd_mode,
  input wire logic [15:0]           rd_field,
  input wire logic [15:0]           rd_ptr,
  input wire logic                  rd_is_byte,
  input wire logic                  rd_valid,
  input wire logic [15:0]           rd_data,
  input wire logic [15:0]           rd_ptr_next,
  // write generator and answer
  input wire logic                  wr_req,
  input wire bads_pkg::bads_amode_e wr_mode,
  input wire logic [15:0]           wr_field,
  input wire logic [15:0]           wr_ptr,
  input wire logic                  wr_is_byte,
  input wire logic                  wr_done,
  input wire logic [15:0]           wr_ptr_next,
  // targets and trap
  input wire logic                  sfr_rd_en,
  input wire logic [9:0]            sfr_rd_addr,
  input wire logic                  sfr_wr_en,
  input wire logic [1:0]            sfr_wr_lane,
  input wire logic [7:0]            program_window_page,
  input wire logic                  pw_rd_en,
  input wire logic [22:0]           pw_rd_addr,
  input wire logic                  addr_err_trap,
  input wire logic                  addr_err_on_read,
  input wire logic                  addr_err_on_write
);
  wire [15:0] rea = (rd_mode == bads_pkg::BADS_AM_NEAR) ? {3'h0, rd_field[12:0]} :
                    (rd_mode == bads_pkg::BADS_AM_DIRECT) ? rd_field : rd_ptr;
  wire [15:0] wea = (wr_mode == bads_pkg::BADS_AM_NEAR) ? {3'h0, wr_field[12:0]} :
                    (wr_mode == bads_pkg::BADS_AM_DIRECT) ? wr_field : wr_ptr;
  wire        rmis = rd_req && !rd_is_byte && rea[0];
  wire        wmis = wr_req && !wr_is_byte && wea[0];
  wire [22:0] rpw  = {program_window_page, rea[14:0]};
  wire [9:0]  rsa  = rea[10:1];
  wire [1:0]  wln  = wea[0] ? 2'h2 : 2'h1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence pw_asked;
    rd_req && rea[15];
  endsequence
  sequence pw_served;
    pw_rd_en && (pw_rd_addr == $past(rpw));
  endsequence

  rd_answer_a: assert property (rd_req |-> ##2 rd_valid)
    else $error("read answer missing");
  wr_answer_a: assert property (wr_req |=> wr_done)
    else $error("write answer missing");
  rd_step_a: assert property (rd_req |-> ##2 rd_ptr_next == $past(rd_ptr, 2) + ($past(rd_is_byte, 2) ? 16'h0001 : 16'h0002))
    else $error("read pointer step wrong");
  wr_step_a: assert property (wr_req |=> wr_ptr_next == $past(wr_ptr) + ($past(wr_is_byte) ? 16'h0001 : 16'h0002))
    else $error("write pointer step wrong");
  rd_misalign_a: assert property (rmis |-> ##2 addr_err_trap && addr_err_on_read)
    else $error("misaligned read not trapped");
  wr_misalign_a: assert property (wmis |=> addr_err_trap && addr_err_on_write && !sfr_wr_en)
    else $error("misaligned write not trapped");
  err_cause_a: assert property ((addr_err_on_read |-> $past(rmis, 2)) and (addr_err_on_write |-> $past(wmis)))
    else $error("trap cause without misaligned access");
  pw_route_a: assert property (pw_asked |=> pw_served)
    else $error("program window address wrong");
  sfr_route_a: assert property (rd_req && rea <= 16'h07FF |=> sfr_rd_en && sfr_rd_addr == $past(rsa))
    else $error("special register read not decoded");
  byte_lane_a: assert property (wr_req && wr_is_byte && wea <= 16'h07FF |=> sfr_wr_en && sfr_wr_lane == $past(wln))
    else $error("byte write lane wrong");
  zero_region_a: assert property (rd_req && rea >= 16'h1000 && rea <= 16'h7FFF |-> ##2 rd_data == 16'h0000)
    else $error("unimplemented read not zero");
  low_lane_a: assert property (rd_req && rd_is_byte |-> ##2 rd_data[15:8] == 8'h00)
    else $error("byte read not on low lane");
endmodule : bads_data_space_chk

bind bads_data_space bads_data_space_chk chk (.*);

// ### dv/byte_addressed_data_space_test.sv
/*
  Directed testbench for the data space decoder with far side model.
  Assumes the design answers reads two edges and writes one edge after taking.
*/
`timescale 1ns/1ps

module byte_addressed_data_space_test;
  logic                  core_clk, reset, rd_req, rd_is_byte, wr_req, wr_is_byte;
  logic                  rd_valid, wr_done, sfr_rd_en, sfr_rd_hit, sfr_wr_en, pw_rd_en;
  logic                  addr_err_trap, addr_err_on_read, addr_err_on_write;
  bads_pkg::bads_amode_e rd_mode, wr_mode;
  bads_pkg::bads_xop_e   rd_op;
  logic [15:0]           rd_field, rd_ptr, rd_wreg_old, rd_data, rd_wreg_result, rd_ptr_next;
  logic [15:0]           wr_field, wr_ptr, wr_data, wr_ptr_next, sfr_rd_data, sfr_wr_data, pw_rd_data;
  logic [9:0]            sfr_rd_addr, sfr_wr_addr;
  logic [1:0]            sfr_wr_lane;
  logic [7:0]            program_window_page;
  logic [22:0]           pw_rd_addr;
  int                    fails, total_checks;

  bads_data_space dut (.*);
  bads_far_model  far (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd_set(input bads_pkg::bads_amode_e m, input logic [15:0] a, input logic b,
                        input bads_pkg::bads_xop_e op, input logic [15:0] old);
    rd_mode = m;
    // field and pointer differ so a mode mix-up reads the wrong place
    rd_field = (m == bads_pkg::BADS_AM_INDIRECT) ? ~a : a;
    rd_ptr = (m == bads_pkg::BADS_AM_INDIRECT) ? a : ~a;
    rd_is_byte = b;
    rd_op = op;
    rd_wreg_old = old;
    rd_req = 1'b1;
  endtask : rd_set

  task automatic wr_set(input bads_pkg::bads_amode_e m, input logic [15:0] a, input logic b, input logic [15:0] d);
    wr_mode = m;
    wr_field = (m == bads_pkg::BADS_AM_INDIRECT) ? ~a : a;
    wr_ptr = (m == bads_pkg::BADS_AM_INDIRECT) ? a : ~a;
    wr_is_byte = b;
    wr_data = d;
    wr_req = 1'b1;
  endtask : wr_set

  // one request, answer judged at the fixed latency
  task automatic rd(input logic [15:0] a, input logic b,
                    input bads_pkg::bads_xop_e op = bads_pkg::BADS_XOP_LOAD, input logic [15:0] old = 16'h0000,
                    input bads_pkg::bads_amode_e m = bads_pkg::BADS_AM_DIRECT);
    @(posedge core_clk); #1;
    rd_set(m, a, b, op, old);
    @(posedge core_clk); #1;
    rd_req = 1'b0;
    @(posedge core_clk); #1;
    chk("rd_valid", {15'h0, rd_valid}, 16'h0001);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic b, input logic [15:0] d,
                    input bads_pkg::bads_amode_e m = bads_pkg::BADS_AM_DIRECT);
    @(posedge core_clk); #1;
    wr_set(m, a, b, d);
    @(posedge core_clk); #1;
    wr_req = 1'b0;
    chk("wr_done", {15'h0, wr_done}, 16'h0001);
  endtask : wr

  task automatic t_lanes;
    wr(16'h0800, 1'b0, 16'h1234);
    rd(16'h0800, 1'b0);
    chk("word", rd_data, 16'h1234);
    rd(16'h0800, 1'b1);
    chk("even byte", rd_data, 16'h0034);
    rd(16'h0801, 1'b1);
    chk("odd byte", rd_data, 16'h0012);
    wr(16'h0802, 1'b0, 16'h5566);
    wr(16'h0803, 1'b1, 16'h00AB);
    rd(16'h0802, 1'b0);
    chk("byte write", rd_data, 16'hAB66);
  endtask : t_lanes

  task automatic t_ops;
    wr(16'h0804, 1'b0, 16'h7F85);
    rd(16'h0804, 1'b1, bads_pkg::BADS_XOP_LOAD, 16'hF0F0);
    chk("byte load", rd_wreg_result, 16'hF085);
    rd(16'h0804, 1'b1, bads_pkg::BADS_XOP_SIGN_EXTEND, 16'hF0F0);
    chk("sign extend", rd_wreg_result, 16'hFF85);
    rd(16'h0805, 1'b1, bads_pkg::BADS_XOP_SIGN_EXTEND, 16'hF0F0);
    chk("sign extend pos", rd_wreg_result, 16'h007F);
    rd(16'h0804, 1'b1, bads_pkg::BADS_XOP_CLEAR_UPPER, 16'hF0F0);
    chk("clear upper", rd_wreg_result, 16'h0085);
  endtask : t_ops

  task automatic t_regions;
    // near write drops field bits 15:13, landing at 0x0006
    wr(16'hE006, 1'b0, 16'hBEEF, bads_pkg::BADS_AM_NEAR);
    rd(16'h0006, 1'b0);
    chk("special reg", rd_data, 16'hBEEF);
    rd(16'hE006, 1'b0, bads_pkg::BADS_XOP_LOAD, 16'h0000, bads_pkg::BADS_AM_NEAR);
    chk("near field", rd_data, 16'hBEEF);
    rd(16'h0400, 1'b0);
    chk("unused special", rd_data, 16'h0000);
    rd(16'h1000, 1'b0);
    chk("gap low", rd_data, 16'h0000);
    rd(16'h7FFE, 1'b0);
    chk("gap high", rd_data, 16'h0000);
    program_window_page = 8'h13;
    rd(16'h8010, 1'b0);
    chk("window", rd_data, 16'h8010 ^ 16'h13C3);
  endtask : t_regions

  task automatic t_misalign;
    wr(16'h0801, 1'b0, 16'hFFFF);
    chk("wr trap", {14'h0, addr_err_trap, addr_err_on_write}, 16'h0003);
    rd(16'h0800, 1'b0);
    chk("write dropped", rd_data, 16'h1234);
    rd(16'h0801, 1'b0);
    chk("rd completes", rd_data, 16'h1234);
    chk("rd trap", {14'h0, addr_err_trap, addr_err_on_read}, 16'h0003);
    rd(16'h0801, 1'b1);
    chk("byte no trap", {15'h0, addr_err_trap}, 16'h0000);
    wr(16'h0007, 1'b0, 16'hFFFF);
    chk("sfr wr trap", {14'h0, addr_err_trap, addr_err_on_write}, 16'h0003);
    rd(16'h0006, 1'b0);
    chk("sfr write dropped", rd_data, 16'hBEEF);
  endtask : t_misalign

  task automatic t_pointers;
    @(posedge core_clk); #1;
    rd_set(bads_pkg::BADS_AM_INDIRECT, 16'h0800, 1'b1, bads_pkg::BADS_XOP_LOAD, 16'h0000);
    wr_set(bads_pkg::BADS_AM_INDIRECT, 16'h0808, 1'b0, 16'h9999);
    @(posedge core_clk); #1;
    rd_req = 1'b0;
    wr_req = 1'b0;
    chk("wr ptr word", wr_ptr_next, 16'h080A);
    @(posedge core_clk); #1;
    chk("parallel rd", rd_data, 16'h0034);
    chk("rd ptr byte", rd_ptr_next, 16'h0801);
    rd(16'h0808, 1'b0);
    chk("indirect wr", rd_data, 16'h9999);
  endtask : t_pointers

  task automatic test_done;
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    #20000;
    fails++;
    test_done;
  end

  initial begin
    fails = 0;
    total_checks = 0;
    reset = 1'b1;
    rd_req = 1'b0;
    wr_req = 1'b0;
    rd_mode = bads_pkg::BADS_AM_DIRECT;
    wr_mode = bads_pkg::BADS_AM_DIRECT;
    rd_op = bads_pkg::BADS_XOP_LOAD;
    {rd_is_byte, wr_is_byte} = 2'h0;
    {rd_field, rd_ptr, rd_wreg_old, wr_field, wr_ptr, wr_data} = 96'h0;
    program_window_page = 8'h00;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    t_lanes;
    t_ops;
    t_regions;
    t_misalign;
    t_pointers;
    test_done;
  end
endmodule : byte_addressed_data_space_test
